// [src/pti_pkg.sv]
package pti_pkg;
    // ten second-level registers, eight events each
    localparam int NUM_REGS = 10;
    localparam int REG_W = 8;
    localparam int NUM_GLOBAL = 4;
    localparam int NUM_SW = 3;
    localparam int NUM_LDO = 3;
    localparam int FIRST_SW = NUM_GLOBAL;
    localparam int FIRST_LDO = NUM_GLOBAL + NUM_SW;
    localparam int IDX_W = 4;
    // first-level flags: global, switcher, ldo groups
    localparam int SYS_W = 3;
    localparam int SYS_GLOBAL_BIT = 0;
    localparam int SYS_SW_BIT = 1;
    localparam int SYS_LDO_BIT = 2;
    localparam logic [REG_W-1:0] STATUS_RST = 8'h00;
    localparam logic [REG_W-1:0] MASK_RST = 8'hFF;
    // pin test pulse
    localparam int CLK_MHZ = 200;
    localparam int TEST_PULSE_US = 100;
    localparam int TEST_PULSE_CYC = TEST_PULSE_US * CLK_MHZ;
    localparam int TEST_CNT_W = 15;
    typedef logic [REG_W-1:0] pti_byte_t;
    typedef enum logic [1:0] {PTI_IDLE, PTI_PULSE} pti_test_state_t;
endpackage

// [src/pti_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface pti_sync_if;
    import pti_pkg::*;
    logic [NUM_REGS*REG_W-1:0] raw;
    logic [NUM_REGS*REG_W-1:0] synced;
    modport src (output raw, input synced);
    modport snk (input raw, output synced);
endinterface
`default_nettype wire

// [src/pti_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pti_sync
    import pti_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // event levels
    pti_sync_if.snk sif
);
    logic [NUM_REGS*REG_W-1:0] meta_reg;
    logic [NUM_REGS*REG_W-1:0] sync_reg;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= sif.raw;
            sync_reg <= meta_reg;
        end
    end
    assign sif.synced = sync_reg;
endmodule
`default_nettype wire

// [src/pti_irq_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// - first-level flag set only when an unmasked latched event exists.
// - irq_out_n low whenever any unmasked event is pending.
// - masked events never reach any first-level flag.
// - events held in ten registers; after the flags, at most four register reads find one.
// - every event has a latched status, a mask and a sense bit.
// - writing one clears a status latch; zero leaves it unchanged.
// - a set mask keeps its event off irq_out_n.
// - sense bit reads the live unlatched event level.
// - four registers carry global system events.
// - three registers carry switcher ov, uv, current_limit_fault faults.
// - three registers carry ldo ov, uv, current_limit_fault faults.
// - pin test request drives irq_out_n low for one 100 us pulse.
module pti_irq_ctrl
    import pti_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // event inputs, asynchronous levels, register r at bits r*8+7..r*8
    input wire logic [NUM_REGS*REG_W-1:0] event_in,
    // host access port, same clock domain
    input wire logic [IDX_W-1:0] host_idx,
    input wire logic status_clr_we,
    input wire logic [REG_W-1:0] status_clr_data,
    input wire logic mask_we,
    input wire logic [REG_W-1:0] mask_wdata,
    input wire logic pin_test_req,
    // read back
    output logic [REG_W-1:0] status_rdata,
    output logic [REG_W-1:0] mask_rdata,
    output logic [REG_W-1:0] sense_rdata,
    output logic [SYS_W-1:0] sys_flags,
    output logic test_busy,
    // interrupt pin
    output logic irq_out_n
);
    pti_sync_if sif();
    logic [NUM_REGS*REG_W-1:0] ev_now;
    logic [NUM_REGS*REG_W-1:0] ev_prev_reg;
    logic [NUM_REGS*REG_W-1:0] status_reg;
    logic [NUM_REGS*REG_W-1:0] status_next;
    logic [NUM_REGS*REG_W-1:0] mask_reg;
    logic [NUM_REGS*REG_W-1:0] mask_next;
    logic [NUM_REGS*REG_W-1:0] pend;
    logic [NUM_REGS-1:0] reg_pend;
    logic [SYS_W-1:0] sys_next;
    logic [REG_W-1:0] status_rd_next;
    logic [REG_W-1:0] mask_rd_next;
    logic [REG_W-1:0] sense_rd_next;
    logic [REG_W-1:0] status_rd_reg;
    logic [REG_W-1:0] mask_rd_reg;
    logic [REG_W-1:0] sense_rd_reg;
    logic [SYS_W-1:0] sys_reg;
    logic irq_n_reg;
    logic idx_ok;
    pti_test_state_t test_state_reg;
    pti_test_state_t test_state_next;
    logic [TEST_CNT_W-1:0] test_cnt_reg;
    logic [TEST_CNT_W-1:0] test_cnt_next;
    logic test_active;
    logic test_start;
    logic grp_global;
    logic grp_sw;
    logic grp_ldo;
    logic any_pend;
    logic irq_next;

    function automatic pti_byte_t pick(
        input logic [NUM_REGS*REG_W-1:0] vec,
        input logic [IDX_W-1:0] idx
    );
        pick = vec[idx*REG_W +: REG_W];
    endfunction

    function automatic logic any_in(
        input logic [NUM_REGS-1:0] v,
        input int lo,
        input int n
    );
        logic r;
        r = 1'b0;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (i >= lo && i < lo + n) begin
                r = r | v[i];
            end
        end
        any_in = r;
    endfunction

    // event levels cross into ref_clk
    assign sif.raw = event_in;
    pti_sync u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .sif(sif)
    );
    assign ev_now = sif.synced;

    assign idx_ok = (host_idx < IDX_W'(NUM_REGS));

    // latch on rising edge; set beats a same-cycle clear
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_reg
            wire [REG_W-1:0] rise;
            wire [REG_W-1:0] clr;
            wire sel;
            assign sel = idx_ok && (host_idx == IDX_W'(g));
            assign rise = ev_now[g*REG_W +: REG_W]
                & ~ev_prev_reg[g*REG_W +: REG_W];
            assign clr = (status_clr_we && sel) ? status_clr_data
                : {REG_W{1'b0}};
            assign status_next[g*REG_W +: REG_W] =
                (status_reg[g*REG_W +: REG_W] & ~clr) | rise;
            assign mask_next[g*REG_W +: REG_W] = (mask_we && sel)
                ? mask_wdata : mask_reg[g*REG_W +: REG_W];
            assign reg_pend[g] = |pend[g*REG_W +: REG_W];
        end
    endgenerate

    // masked latches are removed before any summary
    assign pend = status_reg & ~mask_reg;
    // four global, three switcher, three ldo registers
    assign grp_global = any_in(reg_pend, 0, NUM_GLOBAL);
    assign grp_sw = any_in(reg_pend, FIRST_SW, NUM_SW);
    assign grp_ldo = any_in(reg_pend, FIRST_LDO, NUM_LDO);
    assign sys_next[SYS_GLOBAL_BIT] = grp_global;
    assign sys_next[SYS_SW_BIT] = grp_sw;
    assign sys_next[SYS_LDO_BIT] = grp_ldo;

    // every register belongs to a group, so this matches the flags
    assign any_pend = |reg_pend;
    // pin follows pending events or a running test pulse
    assign irq_next = ~(any_pend | test_active);

    // per-register read back, one host read per bank
    assign status_rd_next = idx_ok ? pick(status_reg, host_idx) : '0;
    assign mask_rd_next = idx_ok ? pick(mask_reg, host_idx) : '0;
    assign sense_rd_next = idx_ok ? pick(ev_now, host_idx) : '0;

    // pin test pulse sequencer
    assign test_active = (test_state_reg == PTI_PULSE);
    // requests during a running pulse are ignored
    assign test_start = (test_state_reg == PTI_IDLE) && pin_test_req;
    always_comb begin
        test_state_next = test_state_reg;
        test_cnt_next = test_cnt_reg;
        case (test_state_reg)
            PTI_IDLE: begin
                if (test_start) begin
                    test_state_next = PTI_PULSE;
                    test_cnt_next = TEST_CNT_W'(TEST_PULSE_CYC - 1);
                end
            end
            PTI_PULSE: begin
                if (test_cnt_reg == '0) begin
                    test_state_next = PTI_IDLE;
                end else begin
                    test_cnt_next = test_cnt_reg - 1'b1;
                end
            end
            default: begin
                test_state_next = PTI_IDLE;
                test_cnt_next = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ev_prev_reg <= '0;
            status_reg <= {NUM_REGS{STATUS_RST}};
            mask_reg <= {NUM_REGS{MASK_RST}};
        end else begin
            ev_prev_reg <= ev_now;
            status_reg <= status_next;
            mask_reg <= mask_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sys_reg <= '0;
            irq_n_reg <= 1'b1;
            status_rd_reg <= '0;
            mask_rd_reg <= '0;
            sense_rd_reg <= '0;
        end else begin
            sys_reg <= sys_next;
            irq_n_reg <= irq_next;
            status_rd_reg <= status_rd_next;
            mask_rd_reg <= mask_rd_next;
            sense_rd_reg <= sense_rd_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            test_state_reg <= PTI_IDLE;
            test_cnt_reg <= '0;
        end else begin
            test_state_reg <= test_state_next;
            test_cnt_reg <= test_cnt_next;
        end
    end

    assign status_rdata = status_rd_reg;
    assign mask_rdata = mask_rd_reg;
    assign sense_rdata = sense_rd_reg;
    assign sys_flags = sys_reg;
    assign test_busy = test_active;
    assign irq_out_n = irq_n_reg;
endmodule
`default_nettype wire

// [bench/pti_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pti_host_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // pin as the host sees it
    input wire logic irq_out_n,
    output logic [31:0] low_cycles
);
    // host polls the pin each cycle and totals time spent low
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) low_cycles <= 32'h0;
        else if (!irq_out_n) low_cycles <= low_cycles + 32'h1;
    end
endmodule
`default_nettype wire

// [bench/pti_irq_ctrl_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module pti_irq_ctrl_checker
    import pti_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // host side
    input wire logic [NUM_REGS*REG_W-1:0] event_in,
    input wire logic [IDX_W-1:0] host_idx,
    input wire logic status_clr_we,
    input wire logic [REG_W-1:0] status_clr_data,
    input wire logic mask_we,
    input wire logic [REG_W-1:0] mask_wdata,
    // outputs
    input wire logic [REG_W-1:0] status_rdata,
    input wire logic [REG_W-1:0] mask_rdata,
    input wire logic [REG_W-1:0] sense_rdata,
    input wire logic [SYS_W-1:0] sys_flags,
    input wire logic test_busy,
    input wire logic irq_out_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic [TEST_CNT_W-1:0] busy_cnt_reg;
    wire logic mapped = host_idx < NUM_REGS;
    wire logic [1:0] grp = host_idx < FIRST_SW ? 2'h0 :
        host_idx < FIRST_LDO ? 2'h1 : 2'h2;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) busy_cnt_reg <= '0;
        else busy_cnt_reg <= test_busy ? busy_cnt_reg + 1'b1 : '0;
    end
    sequence s_held;
        $stable(host_idx) [*2];
    endsequence
    a_mask_write: assert property ((mask_we && mapped) ##1 s_held
        |-> mask_rdata == $past(mask_wdata, 2)) else $error("mask lost");
    a_clear_ones: assert property ((status_clr_we && mapped) ##1 s_held
        |-> (status_rdata & $past(status_clr_data, 2)) == 8'h00)
        else $error("status not cleared");
    a_sense_live: assert property (($stable(event_in) && $stable(host_idx))
        [*5] ##0 mapped |-> sense_rdata == event_in[host_idx*REG_W +: REG_W])
        else $error("sense not live");
    a_unmapped_zero: assert property (!mapped && $stable(host_idx)
        |-> {status_rdata, mask_rdata, sense_rdata} == 24'h000000)
        else $error("unmapped reads nonzero");
    a_pending_flag: assert property (mapped && $stable(host_idx) &&
        (status_rdata & ~mask_rdata) != 8'h00 |-> sys_flags[grp] && !irq_out_n)
        else $error("pending event without flag");
    a_idle_release: assert property (sys_flags == 3'h0 && !test_busy &&
        !$past(test_busy) |-> irq_out_n) else $error("pin low when idle");
    a_test_pulse: assert property ($rose(test_busy)
        |=> !irq_out_n [*8]) else $error("test pulse missing");
    a_test_length: assert property ($fell(test_busy)
        |-> busy_cnt_reg == TEST_PULSE_CYC) else $error("test pulse length");
endmodule
bind pti_irq_ctrl pti_irq_ctrl_checker u_chk (.*);
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pti_pkg::*;
    typedef struct packed {
        logic [IDX_W-1:0] idx;
        pti_byte_t ev;
        pti_byte_t msk;
        logic [SYS_W-1:0] flg;
    } pti_row_t;
    logic ref_clk = 1'b0, rstn = 1'b0, mask_we = 1'b0;
    logic status_clr_we = 1'b0, pin_test_req = 1'b0, test_busy, irq_out_n;
    logic [NUM_REGS*REG_W-1:0] event_in = '0;
    logic [IDX_W-1:0] host_idx = '0;
    pti_byte_t status_clr_data = '0, mask_wdata = '0;
    pti_byte_t status_rdata, mask_rdata, sense_rdata;
    logic [SYS_W-1:0] sys_flags;
    logic [31:0] low_cycles, low_start;
    int errors = 0, tests_run = 0;
    pti_row_t rows [5] = '{'{4'h0, 8'h81, 8'h00, 3'h1},
        '{4'h5, 8'h24, 8'h00, 3'h2}, '{4'h9, 8'h10, 8'h00, 3'h4},
        '{4'h3, 8'h42, 8'hFF, 3'h0}, '{4'h7, 8'h03, 8'h01, 3'h4}};
    pti_irq_ctrl DUT (.*);
    pti_host_model u_host (.*);
    always #2.5 ref_clk = ~ref_clk;
    task automatic check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic is_mask, input pti_byte_t d);
        mask_we <= is_mask;
        status_clr_we <= !is_mask;
        mask_wdata <= d;
        status_clr_data <= d;
        clk(1);
        mask_we <= 1'b0;
        status_clr_we <= 1'b0;
    endtask
    task automatic final_report;
        if (errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #300000;
        errors++;
        final_report;
    end
    initial begin
        clk(16);
        rstn <= 1'b1;
        clk(2);
        check("mask_rst", mask_rdata, MASK_RST);
        check("irq_rst", irq_out_n, 1'b1);
        foreach (rows[i]) begin
            host_idx <= rows[i].idx;
            event_in[rows[i].idx*REG_W +: REG_W] <= rows[i].ev;
            clk(6);
            wr(1'b1, rows[i].msk);
            clk(4);
            check("flags", sys_flags, rows[i].flg);
            check("irq", irq_out_n, rows[i].flg == 3'h0);
            check("status", status_rdata, rows[i].ev);
            check("sense", sense_rdata, rows[i].ev);
            event_in[rows[i].idx*REG_W +: REG_W] <= 8'h00;
            wr(1'b0, ~rows[i].ev);
            clk(4);
            check("keep", status_rdata, rows[i].ev);
            wr(1'b0, rows[i].ev);
            clk(4);
            check("clear", status_rdata, 8'h00);
            check("flags_clr", sys_flags, 3'h0);
            check("irq_clr", irq_out_n, 1'b1);
            wr(1'b1, 8'hFF);
            clk(1);
        end
        host_idx <= 4'hC;
        wr(1'b1, 8'h00);
        clk(3);
        check("unmapped", mask_rdata, 8'h00);
        low_start = low_cycles;
        pin_test_req <= 1'b1;
        clk(1);
        pin_test_req <= 1'b0;
        clk(2);
        for (int n = 0; n < 30000 && test_busy !== 1'b0; n++) clk(1);
        check("busy_end", test_busy, 1'b0);
        clk(4);
        check("pulse", low_cycles - low_start, TEST_PULSE_CYC);
        final_report;
    end
endmodule
`default_nettype wire
